// file: lpw_pkg.sv
package lpw_pkg;
	// ==========================================
	// Register map (APB byte addresses)
	localparam logic [7:0] LPW_ADDR_SENSE   = 8'h00;
	localparam logic [7:0] LPW_ADDR_PINSEL  = 8'h04;
	localparam logic [7:0] LPW_ADDR_MODECTL = 8'h08;
	localparam logic [7:0] LPW_ADDR_STATUS  = 8'h0C;
	localparam logic [7:0] LPW_ADDR_PEND    = 8'h10;
	// ==========================================
	// Reset values
	localparam logic [7:0] LPW_SENSE_RST  = 8'h00;
	localparam logic [7:0] LPW_PINSEL_RST = 8'h0C;
	// ==========================================
	// Mode control fields
	localparam int LPW_MC_SLOW_BIT   = 0;
	localparam int LPW_MC_AHALT_BIT  = 1;
	localparam int LPW_MC_AUTO_WAKE_ENABLE_BIT  = 2;
	localparam int LPW_MC_WDG_BIT    = 3;
	// ==========================================
	// Sensitivity codes
	localparam logic [1:0] LPW_SENSE_FALL_LOW = 2'h0;
	localparam logic [1:0] LPW_SENSE_RISE     = 2'h1;
	localparam logic [1:0] LPW_SENSE_FALL     = 2'h2;
	localparam logic [1:0] LPW_SENSE_BOTH     = 2'h3;
	// ==========================================
	// Timing
	localparam int LPW_SLOW_DIV       = 32;
	localparam int LPW_STAB_SHORT     = 256;
	localparam int LPW_STAB_LONG      = 4096;
	localparam int LPW_STARTUP_NS     = 1000;
	localparam int LPW_CLK_PERIOD_NS  = 50;
	localparam int LPW_STARTUP_CYC    = (LPW_STARTUP_NS + LPW_CLK_PERIOD_NS - 1) / LPW_CLK_PERIOD_NS;
	localparam int LPW_LINES          = 4;
	typedef enum logic [2:0] {
		LPW_RUN,
		LPW_SLOW,
		LPW_WAIT,
		LPW_SLOW_WAIT,
		LPW_HALT,
		LPW_STAB
	} lpw_state_type;
endpackage

// file: lpw_line_if.sv
interface lpw_line_if;
	logic       pin;
	logic [1:0] sense;
	logic       sense_chg;
	logic       ack;
	logic       pend;
	modport det (input pin, input sense, input sense_chg, input ack, output pend);
	modport ctl (output pin, output sense, output sense_chg, output ack, input pend);
endinterface

// file: lpw_line_det.sv
module lpw_line_det
	import lpw_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	lpw_line_if.det   line
);
	logic [2:0] sync_q;
	logic       prev_q;
	logic       pend_q;
	logic       rise;
	logic       fall;
	logic       hit;

	// ==========================================
	// Synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			sync_q <= 3'h7;
		else
			sync_q <= {sync_q[1:0], line.pin};
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			prev_q <= 1'b1;
		else if (sync_q[1] == sync_q[2])
			prev_q <= sync_q[2];
	end

	assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !prev_q;
	assign fall = (sync_q[1] == sync_q[2]) && !sync_q[2] && prev_q;

	always_comb
	begin
		hit = 1'b0;
		unique case (line.sense)
			LPW_SENSE_FALL_LOW: hit = fall;
			LPW_SENSE_RISE:     hit = rise;
			LPW_SENSE_FALL:     hit = fall;
			LPW_SENSE_BOTH:     hit = rise || fall;
		endcase
	end

	// ==========================================
	// Edge latch; a new edge beats the acknowledge in the same cycle
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pend_q <= 1'b0;
		else if (hit)
			pend_q <= 1'b1;
		else if (line.ack || line.sense_chg)
			pend_q <= 1'b0;
	end

	// Low level keeps the request alive as long as the pin stays low
	assign line.pend = pend_q || (line.sense == LPW_SENSE_FALL_LOW && prev_q == 1'b0);

	a_sense_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		line.sense_chg && !hit |=> !pend_q)
		else $error("pending edge survived a sensitivity change");
	a_edge_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hit |=> pend_q)
		else $error("detected edge not latched");
endmodule

// file: lpw_top.sv
// How it works
// - Sensitivity register: line 3 bits 7:6 down to line 0 bits 1:0.
// - Code 00 fall plus low, 01 rise, 10 fall, 11 both edges.
// - Sensitivity writes are taken only while the interrupt mask is set.
// - Changing a line's sensitivity clears its pending request.
// - Line 3 select bits 7:6 pick port B bit 0, 1 or 2.
// - Line 2 select bits 5:4 pick port B bits 3 to 6.
// - Port B bit 4 on line 2 never wakes from halt.
// - Line 1 select bits 3:2 pick port A bits 4 to 7, reset 7.
// - Line 0 select bits 1:0 pick port A bits 0 to 3, reset 0.
// - Reset enters run mode with core and peripherals clocked.
// - Slow select divides the clock by 32 for core and peripherals.
// - Wait entered during slow mode becomes slow-wait on the divided clock.
// - Wait stops the core, keeps peripherals clocked, clears the mask.
// - Wait ends on interrupt or reset, then the core is vectored.
// - Halt goes to plain halt only with active-halt and auto-wake off.
// - Halt exit restarts oscillator then waits 256 or 4096 core cycles.
// - Entering halt forces the mask to 0 for immediate wake on pending.
// - Halt stops the oscillator and all internally clocked processing.
// - Halt with watchdog enabled may give a watchdog reset instead.
// - With the multiplier enabled, an extra startup delay follows halt exit.
// - Service pushes flags, holds mask set, clears on pop.
// - Edge requests latch and clear when service starts.
//
// Decided for this implementation: the APB slave port and the register addresses.
module lpw_top
	import lpw_pkg::*;
#(
	parameter int STAB_LONG_CYC = LPW_STAB_LONG
)
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic [7:0]  port_a_in,
	input  wire logic [6:0]  port_b_in,
	input  wire logic        wfi_instr_in,
	input  wire logic        halt_instr_in,
	input  wire logic        irq_mask_in,
	input  wire logic        isr_enter_in,
	input  wire logic [1:0]  isr_line_in,
	input  wire logic        isr_return_in,
	input  wire logic        stab_long_in,
	input  wire logic        mult_en_in,
	input  wire logic        watchdog_active_in,
	output logic             clear_mask_out,
	output logic             set_mask_out,
	output logic             push_flags_out,
	output logic             pop_flags_out,
	output logic             core_clk_en_out,
	output logic             periph_clk_en_out,
	output logic             osc_on_out,
	output logic             wake_out,
	output logic [3:0]       irq_req_out,
	output logic             wdg_reset_out,
	output logic [2:0]       mode_out
);
	logic [1:0]    rst_sync_q;
	logic          rst_n;
	lpw_state_type state_q;
	logic [7:0]    sense_q;
	logic [7:0]    pinsel_q;
	logic [3:0]    modectl_q;
	logic [4:0]    div_q;
	logic          slow_tick;
	logic [12:0]   stab_q;
	logic [3:0]    line_pend;
	logic [3:0]    line_pins;
	logic [3:0]    sense_chg;
	logic          halt_wake;
	logic          access;
	logic          wr;
	logic          sense_wr;
	logic          mask_now;

	// ==========================================
	// Reset release
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// ==========================================
	// APB slave, zero wait states
	assign access      = psel_in && penable_in;
	assign wr          = access && pwrite_in;
	assign pready_out  = 1'b1;
	assign pslverr_out = access && !(paddr_in == LPW_ADDR_SENSE || paddr_in == LPW_ADDR_PINSEL
		|| paddr_in == LPW_ADDR_MODECTL || paddr_in == LPW_ADDR_STATUS || paddr_in == LPW_ADDR_PEND);
	assign sense_wr    = wr && paddr_in == LPW_ADDR_SENSE && irq_mask_in;

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			sense_q <= LPW_SENSE_RST;
		else if (sense_wr)
			sense_q <= pwdata_in[7:0];
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			pinsel_q <= LPW_PINSEL_RST;
		else if (wr && paddr_in == LPW_ADDR_PINSEL)
			pinsel_q <= pwdata_in[7:0];
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			modectl_q <= 4'h0;
		else if (wr && paddr_in == LPW_ADDR_MODECTL)
			modectl_q <= pwdata_in[3:0];
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			prdata_out <= 32'h0;
		else if (psel_in && !penable_in && !pwrite_in)
		begin
			unique case (paddr_in)
				LPW_ADDR_SENSE:   prdata_out <= {24'h0, sense_q};
				LPW_ADDR_PINSEL:  prdata_out <= {24'h0, pinsel_q};
				LPW_ADDR_MODECTL: prdata_out <= {28'h0, modectl_q};
				LPW_ADDR_STATUS:  prdata_out <= {29'h0, mode_out};
				LPW_ADDR_PEND:    prdata_out <= {28'h0, line_pend};
				default:          prdata_out <= 32'h0;
			endcase
		end
	end

	// ==========================================
	// Pin routing; line 3 code 11 is unused and falls back to bit 0
	always_comb
	begin
		unique case (pinsel_q[7:6])
			2'h1:    line_pins[3] = port_b_in[1];
			2'h2:    line_pins[3] = port_b_in[2];
			default: line_pins[3] = port_b_in[0];
		endcase
		line_pins[2] = port_b_in[3 + 32'(pinsel_q[5:4])];
		line_pins[1] = port_a_in[4 + 32'(pinsel_q[3:2])];
		line_pins[0] = port_a_in[32'(pinsel_q[1:0])];
	end

	// ==========================================
	// Line detectors
	genvar g;
	generate
		for (g = 0; g < LPW_LINES; g++)
		begin : g_line
			lpw_line_if lif ();
			assign lif.pin       = line_pins[g];
			assign lif.sense     = sense_q[2*g +: 2];
			assign lif.sense_chg = sense_chg[g];
			assign lif.ack       = isr_enter_in && isr_line_in == 2'(g);
			assign line_pend[g]  = lif.pend;
			assign sense_chg[g]  = sense_wr && pwdata_in[2*g +: 2] != sense_q[2*g +: 2];
			lpw_line_det u_det (
				.clk_in   (clk_sys_in),
				.rst_n_in (rst_n),
				.line     (lif)
			);
		end
	endgenerate

	assign irq_req_out = line_pend;
	// Port B bit 4 on line 2 cannot wake from halt
	assign halt_wake = |{line_pend[3], line_pend[2] && pinsel_q[5:4] != 2'h1,
		line_pend[1:0]};

	// ==========================================
	// Slow divider
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			div_q <= 5'h0;
		else
			div_q <= div_q + 5'h1;
	end
	assign slow_tick = div_q == 5'(LPW_SLOW_DIV - 1);

	// ==========================================
	// Mode sequencer
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= LPW_RUN;
		else
		begin
			unique case (state_q)
				LPW_RUN, LPW_SLOW:
				begin
					if (halt_instr_in && !modectl_q[LPW_MC_AHALT_BIT] && !modectl_q[LPW_MC_AUTO_WAKE_ENABLE_BIT]
						&& !(watchdog_active_in && modectl_q[LPW_MC_WDG_BIT]))
						state_q <= LPW_HALT;
					else if (wfi_instr_in)
						state_q <= (state_q == LPW_SLOW) ? LPW_SLOW_WAIT : LPW_WAIT;
					else
						state_q <= modectl_q[LPW_MC_SLOW_BIT] ? LPW_SLOW : LPW_RUN;
				end
				LPW_WAIT, LPW_SLOW_WAIT:
					if (|line_pend)
						state_q <= modectl_q[LPW_MC_SLOW_BIT] ? LPW_SLOW : LPW_RUN;
				LPW_HALT:
					if (halt_wake)
						state_q <= LPW_STAB;
				LPW_STAB:
					if (stab_q == 13'h0)
						state_q <= modectl_q[LPW_MC_SLOW_BIT] ? LPW_SLOW : LPW_RUN;
				default:
					state_q <= LPW_RUN;
			endcase
		end
	end

	// Stabilisation counter, plus multiplier startup when enabled
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			stab_q <= 13'h0;
		else if (state_q == LPW_HALT && halt_wake)
			stab_q <= 13'((stab_long_in ? STAB_LONG_CYC : LPW_STAB_SHORT) - 1
				+ (mult_en_in ? LPW_STARTUP_CYC : 0));
		else if (state_q == LPW_STAB && stab_q != 13'h0)
			stab_q <= stab_q - 13'h1;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			wdg_reset_out <= 1'b0;
		else
			wdg_reset_out <= (state_q == LPW_RUN || state_q == LPW_SLOW) && halt_instr_in
				&& watchdog_active_in && modectl_q[LPW_MC_WDG_BIT];
	end

	// ==========================================
	// Core side strobes and clock gating
	assign clear_mask_out = (state_q == LPW_RUN || state_q == LPW_SLOW)
		&& (wfi_instr_in || halt_instr_in);
	assign wake_out       = (state_q == LPW_STAB && stab_q == 13'h0)
		|| ((state_q == LPW_WAIT || state_q == LPW_SLOW_WAIT) && |line_pend);
	assign push_flags_out = isr_enter_in;
	assign set_mask_out   = isr_enter_in;
	assign pop_flags_out  = isr_return_in;
	assign mask_now       = irq_mask_in;

	always_comb
	begin
		core_clk_en_out   = 1'b0;
		periph_clk_en_out = 1'b0;
		osc_on_out        = 1'b1;
		unique case (state_q)
			LPW_RUN:
			begin
				core_clk_en_out   = 1'b1;
				periph_clk_en_out = 1'b1;
			end
			LPW_SLOW:
			begin
				core_clk_en_out   = slow_tick;
				periph_clk_en_out = slow_tick;
			end
			LPW_WAIT:      periph_clk_en_out = 1'b1;
			LPW_SLOW_WAIT: periph_clk_en_out = slow_tick;
			LPW_HALT:      osc_on_out = 1'b0;
			default:       osc_on_out = 1'b1;
		endcase
	end
	assign mode_out = state_q;

	a_halt_osc: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_HALT |-> !osc_on_out && !core_clk_en_out)
		else $error("clocks running in halt");
	a_wait_mask: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_RUN && wfi_instr_in && !halt_instr_in |-> clear_mask_out ##1 state_q == LPW_WAIT)
		else $error("wait entry wrong");
	a_sense_lock: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		!mask_now |=> $stable(sense_q))
		else $error("sensitivity changed while mask clear");
	a_stab_short: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_HALT && halt_wake && !stab_long_in && !mult_en_in
		|=> state_q == LPW_STAB ##255 wake_out)
		else $error("short stabilisation length wrong");
	a_pb4_nowake: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_HALT && line_pend == 4'h4 && pinsel_q[5:4] == 2'h1 |=> state_q == LPW_HALT)
		else $error("port B bit 4 woke halt");
	a_slow_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_SLOW && wfi_instr_in && !halt_instr_in |=> state_q == LPW_SLOW_WAIT)
		else $error("slow-wait not entered");
	a_halt_entry: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_RUN && halt_instr_in && (modectl_q[LPW_MC_AHALT_BIT] || modectl_q[LPW_MC_AUTO_WAKE_ENABLE_BIT])
		|=> state_q != LPW_HALT)
		else $error("halt entered while disabled");
	a_slow_rate: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_SLOW && core_clk_en_out |=> !core_clk_en_out)
		else $error("slow clock enable too frequent");

	// ==========================================
	// Sequencer and sensitivity write checks
	a_run_clocks: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_RUN |-> core_clk_en_out && periph_clk_en_out && osc_on_out)
		else $error("run mode clocks wrong");
	a_sense_take: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		sense_wr |=> sense_q == $past(pwdata_in[7:0]))
		else $error("sensitivity write lost");
	a_halt_mask: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		(state_q == LPW_RUN || state_q == LPW_SLOW) && halt_instr_in |-> clear_mask_out)
		else $error("mask not cleared on halt");
	a_wait_clocks: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_WAIT |-> periph_clk_en_out && !core_clk_en_out && osc_on_out)
		else $error("wait mode clocks wrong");
	a_slow_wait_clk: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_SLOW_WAIT |-> !core_clk_en_out && periph_clk_en_out == slow_tick)
		else $error("slow-wait clocks wrong");
	a_wait_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		(state_q == LPW_WAIT || state_q == LPW_SLOW_WAIT) && !(|line_pend) |=> state_q == $past(state_q))
		else $error("wait left without a request");
	a_wait_wake: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		(state_q == LPW_WAIT || state_q == LPW_SLOW_WAIT) && (|line_pend)
		|-> wake_out ##1 (state_q == LPW_RUN || state_q == LPW_SLOW))
		else $error("wait not ended by request");
	a_wake_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		wake_out |=> !wake_out)
		else $error("wake strobe longer than one cycle");
	a_stab_osc: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_STAB |-> osc_on_out && !core_clk_en_out && !periph_clk_en_out)
		else $error("stabilisation clocks wrong");
	a_stab_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_STAB && stab_q != 13'h0 |=> state_q == LPW_STAB)
		else $error("stabilisation cut short");
	a_long_delay: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		state_q == LPW_HALT && halt_wake && stab_long_in && mult_en_in
		|=> stab_q == 13'(STAB_LONG_CYC - 1 + LPW_STARTUP_CYC))
		else $error("long delay with startup wrong");
	a_wdg_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
		(state_q == LPW_RUN || state_q == LPW_SLOW) && halt_instr_in && watchdog_active_in
		&& modectl_q[LPW_MC_WDG_BIT] |=> wdg_reset_out && state_q != LPW_HALT)
		else $error("watchdog option ignored on halt");
endmodule

// file: lpw_core_model.sv
module lpw_core_model
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       sei_in,
	input  wire logic       wfi_req_in,
	input  wire logic       halt_req_in,
	input  wire logic       svc_en_in,
	input  wire logic       clear_mask_in,
	input  wire logic [3:0] irq_req_in,
	input  wire logic [2:0] mode_in,
	output logic            wfi_out,
	output logic            halt_out,
	output logic            mask_out,
	output logic            enter_out,
	output logic [1:0]      line_out,
	output logic            ret_out
);
	// ==========================================
	// Instruction strobes and one-cycle service routine
	always_ff @(posedge clk_in)
	begin
		wfi_out <= wfi_req_in;
		halt_out <= halt_req_in;
		ret_out <= enter_out;
		line_out <= irq_req_in[0] ? 2'h0 : irq_req_in[1] ? 2'h1 : irq_req_in[2] ? 2'h2 : 2'h3;
	end
	// Core only vectors once it runs again, never while stopped
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			enter_out <= 1'b0;
		else
			enter_out <= svc_en_in && !mask_out && !enter_out && !ret_out && (|irq_req_in) && mode_in <= 3'h1;
	end
	// ==========================================
	// Interrupt mask bit as the core holds it
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			mask_out <= 1'b0;
		else if (clear_mask_in)
			mask_out <= 1'b0;
		else if (enter_out)
			mask_out <= 1'b1;
		else if (ret_out)
			mask_out <= 1'b0;
		else if (sei_in)
			mask_out <= 1'b1;
	end
endmodule

// file: lpw_top_tb.sv
module lpw_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lpw_pkg::*;
	logic        clk, rst_n, psel, pen, pwr, prdy, perr, wait_for_interrupt_instr, hlt, msk, ent, ret;
	logic        clm, stm, push, pop, cen, pcen, osc, wake, wdg, slong, mult, wact;
	logic        sei, wreq, hreq, svc, er;
	logic [7:0]  paddr, sel;
	logic [31:0] pwd, prd, rd, seed;
	logic [14:0] pins;
	logic [1:0]  iln;
	logic [3:0]  irq;
	logic [2:0]  mode;
	int          mismatches, n_checks;
	lpw_top #(.STAB_LONG_CYC(300)) i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(prdy), .pslverr_out(perr), .port_a_in(pins[7:0]), .port_b_in(pins[14:8]),
		.wfi_instr_in(wait_for_interrupt_instr), .halt_instr_in(hlt), .irq_mask_in(msk), .isr_enter_in(ent),
		.isr_line_in(iln), .isr_return_in(ret), .stab_long_in(slong), .mult_en_in(mult),
		.watchdog_active_in(wact), .clear_mask_out(clm), .set_mask_out(stm), .push_flags_out(push),
		.pop_flags_out(pop), .core_clk_en_out(cen), .periph_clk_en_out(pcen), .osc_on_out(osc),
		.wake_out(wake), .irq_req_out(irq), .wdg_reset_out(wdg), .mode_out(mode));
	lpw_core_model i_core (.clk_in(clk), .rst_n_in(rst_n), .sei_in(sei), .wfi_req_in(wreq),
		.halt_req_in(hreq), .svc_en_in(svc), .clear_mask_in(clm), .irq_req_in(irq), .mode_in(mode),
		.wfi_out(wait_for_interrupt_instr), .halt_out(hlt), .mask_out(msk), .enter_out(ent), .line_out(iln), .ret_out(ret));
	// ==========================================
	// Helpers
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function int pin_of(int l, logic [7:0] s);
		if (l == 0)
			return s[1:0];
		if (l == 1)
			return 4 + s[3:2];
		if (l == 2)
			return 11 + s[5:4];
		return (s[7:6] == 2'h3) ? 8 : 8 + s[7:6];
	endfunction
	function logic pend_exp(int c, int e);
		return e ? (c == 1 || c == 3) : (c != 1);
	endfunction
	task wrap_up();
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task tmo(input string nm);
		chk(nm, 32'h1, 32'h0);
		wrap_up();
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Full setup/access cycle; request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (prdy !== 1'b1 && k < 20);
		if (prdy !== 1'b1)
			tmo("pready");
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task pulse(input int w);
		wreq <= (w == 0);
		hreq <= (w == 1);
		sei <= (w == 2);
		@(posedge clk);
		{wreq, hreq, sei} <= 3'h0;
	endtask
	task wmode(input logic [2:0] m, input int lim);
		int k;
		k = 0;
		while (mode !== m && k < lim)
		begin
			@(negedge clk);
			k++;
		end
		if (mode !== m)
			tmo("mode");
		@(posedge clk);
	endtask
	task cnt(output int a, output int b);
		a = 0;
		b = 0;
		repeat (64)
		begin
			@(negedge clk);
			a += cen;
			b += pcen;
		end
		@(posedge clk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ==========================================
	// Main sequence
	initial
	begin
		int c, e, l, a, b, n, x;
		{psel, pen, pwr, sei, wreq, hreq, svc, slong, mult, wact} = '0;
		{paddr, pwd} = '0;
		pins = '1;
		seed = 32'h8CC315C7;
		mismatches = 0;
		n_checks = 0;
		rst_n = 1'b0;
		wt(16);
		rst_n <= 1'b1;
		wt(3);
		@(negedge clk);
		chk("mode", 32'h0, mode);
		chk("clocks", 32'h7, {cen, pcen, osc});
		@(posedge clk);
		apb(1'b0, LPW_ADDR_SENSE, 32'h0);
		chk("sense_rst", 32'h0, rd);
		apb(1'b0, LPW_ADDR_PINSEL, 32'h0);
		chk("pinsel_rst", 32'h0C, rd);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b1, LPW_ADDR_SENSE, 32'hFF);
		apb(1'b0, LPW_ADDR_SENSE, 32'h0);
		chk("sense_masked", 32'h0, rd);
		pulse(2);
		apb(1'b1, LPW_ADDR_SENSE, 32'hFF);
		apb(1'b0, LPW_ADDR_SENSE, 32'h0);
		chk("sense_wr", 32'hFF, rd);
		for (l = 0; l < 4; l++)
			for (c = 0; c < 4; c++)
				for (e = 0; e < 2; e++)
				begin
					if (e == 1 && c == 0)
						continue;
					sel = 8'(xs());
					x = pin_of(l, sel);
					apb(1'b1, LPW_ADDR_PINSEL, {24'h0, sel});
					apb(1'b0, LPW_ADDR_PINSEL, 32'h0);
					chk("pinsel", {24'h0, sel}, rd);
					pins[x] <= (e == 0);
					wt(8);
					apb(1'b1, LPW_ADDR_SENSE, 32'(c << (2 * l)));
					pins[x] <= (e == 1);
					wt(8);
					@(negedge clk);
					chk("irq_req", {31'h0, pend_exp(c, e)}, {31'h0, irq[l]});
					@(posedge clk);
					apb(1'b0, LPW_ADDR_PEND, 32'h0);
					chk("pend_reg", {31'h0, pend_exp(c, e)}, {31'h0, rd[l]});
					pins <= '1;
					wt(8);
					apb(1'b1, LPW_ADDR_SENSE, 32'((c ^ 1) << (2 * l)));
					@(negedge clk);
					chk("irq_clear", 32'h0, {31'h0, irq[l]});
					@(posedge clk);
				end
		apb(1'b1, LPW_ADDR_PINSEL, 32'h0C);
		apb(1'b1, LPW_ADDR_SENSE, 32'h02);
		svc <= 1'b1;
		pulse(0);
		wmode(3'h2, 20);
		@(negedge clk);
		chk("wait_clk", 32'h1, {cen, pcen});
		chk("wait_mask", 32'h0, {31'h0, msk});
		repeat (20) @(negedge clk);
		chk("wait_hold", 32'h2, mode);
		@(posedge clk);
		apb(1'b0, LPW_ADDR_STATUS, 32'h0);
		chk("status", 32'h2, rd);
		pins[0] <= 1'b0;
		wmode(3'h0, 40);
		n = 0;
		while (push !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		chk("push", 32'h1, {31'h0, push});
		chk("set_mask", 32'h1, {31'h0, stm});
		@(negedge clk);
		chk("ack", 32'h0, {31'h0, irq[0]});
		chk("pop", 32'h1, {31'h0, pop});
		@(posedge clk);
		pins <= '1;
		apb(1'b1, LPW_ADDR_MODECTL, 32'h1);
		wmode(3'h1, 10);
		cnt(a, b);
		chk("slow_clk", 32'h22, {a[3:0], b[3:0]});
		pulse(0);
		wmode(3'h3, 100);
		cnt(a, b);
		chk("slow_wait_clk", 32'h02, {a[3:0], b[3:0]});
		pins[0] <= 1'b0;
		wmode(3'h1, 200);
		pins <= '1;
		apb(1'b1, LPW_ADDR_MODECTL, 32'h0);
		wmode(3'h0, 100);
		for (e = 0; e < 2; e++)
		begin
			slong <= e[0];
			mult <= e[0];
			pulse(1);
			wmode(3'h4, 10);
			@(negedge clk);
			chk("halt_clk", 32'h0, {osc, cen, pcen});
			chk("halt_mask", 32'h0, {31'h0, msk});
			@(posedge clk);
			pins[0] <= 1'b0;
			wmode(3'h5, 20);
			n = 0;
			while (wake !== 1'b1 && n < 500)
			begin
				@(negedge clk);
				n++;
			end
			x = e ? 300 + LPW_STARTUP_CYC : LPW_STAB_SHORT;
			chk("stab_len", 32'h1, {31'h0, n >= x - 2 && n <= x + 2});
			@(posedge clk);
			pins <= '1;
			wmode(3'h0, 10);
			wt(10);
		end
		pulse(2);
		apb(1'b1, LPW_ADDR_PINSEL, 32'h1C);
		apb(1'b1, LPW_ADDR_SENSE, 32'h20);
		pulse(1);
		wmode(3'h4, 10);
		pins[12] <= 1'b0;
		repeat (40) @(negedge clk);
		chk("pb4_halt", 32'h4, mode);
		@(posedge clk);
		pins[0] <= 1'b0;
		wmode(3'h5, 20);
		wmode(3'h0, 400);
		pins <= '1;
		wt(10);
		for (l = 1; l < 3; l++)
		begin
			apb(1'b1, LPW_ADDR_MODECTL, 32'(1 << l));
			pulse(1);
			repeat (20) @(negedge clk);
			chk("halt_gate", 32'h1, {31'h0, mode !== 3'h4});
			@(posedge clk);
		end
		wact <= 1'b1;
		apb(1'b1, LPW_ADDR_MODECTL, 32'h08);
		pulse(1);
		n = 0;
		while (wdg !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		chk("wdg_rst", 32'h1, {31'h0, wdg});
		@(posedge clk);
		rst_n <= 1'b0;
		wt(16);
		rst_n <= 1'b1;
		wt(3);
		@(negedge clk);
		chk("mode_rst", 32'h0, mode);
		wrap_up();
	end
endmodule
